// [hdl/hwdc_pkg.sv]
// Purpose: shared constants for the hardware and watchdog control register pair
// Assumes: 16-bit registers on a 7-bit register address port, 100 MHz clk_sys
// Notes:   masks name the writable fields; everything else reads zero
package hwdc_pkg;
	// register addresses on the control port
	localparam logic [6:0]  ADDR_MODE_SUPPLY = 7'h01;
	localparam logic [6:0]  ADDR_HARD_CTL    = 7'h02;
	localparam logic [6:0]  ADDR_WDG_CTL     = 7'h03;

	// mode field of the mode and supply register
	localparam int          MODE_HI          = 15;
	localparam int          MODE_LO          = 14;
	localparam logic [1:0]  MODE_NORMAL      = 2'h0;
	localparam logic [1:0]  MODE_STOP        = 2'h2;
	localparam logic [1:0]  MODE_SOFT_RESET  = 2'h3;

	// hardware control field positions
	localparam int          HC_THERM_DLY     = 12;
	localparam int          HC_SUPPLY_OV     = 11;
	localparam int          HC_SH_OFF        = 10;
	localparam int          HC_RST_DLY       = 9;
	localparam int          HC_SOFT_PIN      = 6;
	localparam int          HC_STOP_WDG_HI   = 2;

	// hardware control masks and reset values
	localparam logic [15:0] HC_WR_MASK       = 16'h1e44;
	localparam logic [15:0] HC_POR_VAL       = 16'h0000;
	localparam logic [15:0] HC_SOFT_KEEP     = 16'h0200;
	localparam logic [15:0] HC_RESTART_KEEP  = 16'h1240;

	// watchdog control field positions
	localparam int          WC_CHECKSUM      = 15;
	localparam int          WC_STOP_WDG_LO   = 6;
	localparam int          WC_TYPE          = 5;
	localparam int          WC_BUS_WAKE      = 4;
	localparam int          WC_PER_HI        = 2;
	localparam int          WC_PER_LO        = 0;

	// watchdog control masks and reset values
	localparam logic [15:0] WC_WR_MASK       = 16'h8077;
	localparam logic [15:0] WC_POR_VAL       = 16'h0014;
	localparam logic [15:0] WC_RESTART_KEEP  = 16'h0010;
	localparam logic [15:0] WC_RESTART_SET   = 16'h0004;

	// thermal shutdown run length beyond which the long wait applies
	localparam logic [4:0]  THERM_RUN_LIMIT  = 5'h10;
	localparam logic [4:0]  THERM_RUN_SAT    = 5'h11;

	// watchdog period per code in milliseconds; code 110 read as 1 s
	localparam logic [13:0] WDG_MS_C0        = 14'h000a;
	localparam logic [13:0] WDG_MS_C1        = 14'h0014;
	localparam logic [13:0] WDG_MS_C2        = 14'h0032;
	localparam logic [13:0] WDG_MS_C3        = 14'h0064;
	localparam logic [13:0] WDG_MS_C4        = 14'h00c8;
	localparam logic [13:0] WDG_MS_C5        = 14'h01f4;
	localparam logic [13:0] WDG_MS_C6        = 14'h03e8;
	localparam logic [13:0] WDG_MS_C7        = 14'h2710;

	// reset output delay times
	localparam int          CLK_PERIOD_NS    = 10;
	localparam int          RST_DLY_LONG_MS  = 10;
	localparam int          RST_DLY_SHORT_MS = 2;
	localparam int          RST_DLY_LONG_CYC = RST_DLY_LONG_MS * 1000000 / CLK_PERIOD_NS;
	localparam int          RST_DLY_SHRT_CYC = RST_DLY_SHORT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int          RST_CNT_W        = 20;
endpackage

// [hdl/hwdc_rst_pulse.sv]
// Purpose: timed low pulse on the active-low reset output
// Assumes: start is a one-cycle pulse, shortSel stable while it is high
// Notes:   a new start restarts the delay from the full count
`timescale 1ns/1ps
`default_nettype none
module hwdc_rst_pulse #(
	parameter int LONG_CYC  = hwdc_pkg::RST_DLY_LONG_CYC,
	parameter int SHORT_CYC = hwdc_pkg::RST_DLY_SHRT_CYC
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic shortSel,
	output logic      pinN
);
	localparam logic [hwdc_pkg::RST_CNT_W-1:0] LONG_V  = LONG_CYC[hwdc_pkg::RST_CNT_W-1:0];
	localparam logic [hwdc_pkg::RST_CNT_W-1:0] SHORT_V = SHORT_CYC[hwdc_pkg::RST_CNT_W-1:0];

	logic [hwdc_pkg::RST_CNT_W-1:0] cnt_ff;
	logic                           pinN_ff;

	// power-on holds the pin low for the long delay after release
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_ff  <= LONG_V;
			pinN_ff <= 1'b0;
		end else if (start) begin
			cnt_ff  <= shortSel ? SHORT_V : LONG_V;
			pinN_ff <= 1'b0;
		end else if (cnt_ff != '0) begin
			cnt_ff  <= cnt_ff - 1'b1;
			pinN_ff <= 1'b0;
		end else begin
			pinN_ff <= 1'b1;
		end
	end

	assign pinN = pinN_ff;
endmodule
`default_nettype wire

// [hdl/hwdc_ctrl_regs.sv]
// Purpose: hardware control and watchdog control registers of the motor system chip
// Assumes: register port strobes are one-cycle pulses synchronous to clk_sys
// Notes:   rst is power-on reset; soft reset comes from a mode write, restart from a pin
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - bit 12 selects short or extended thermal wait
// - bit 11 selects 20V or 30V overvoltage threshold
// - bit 10 set disables gate sample-and-hold
// - bit 9 selects 10 ms or 2 ms
// - bit 6 clear pulls reset low on soft reset
// - two bits mark watchdog off in stop mode
// - stop to normal clears the hardware stop bit
// - watchdog bit 5 selects timeout or window type
// - watchdog bit 4 starts watchdog after bus wake
// - bits 2:0 select the watchdog period
// - bit 15 is a host-set checksum bit
// - reserved bits always read zero
// - power-on clears; soft reset keeps bit 9
// - restart keeps bits 12, 9, 6 only
// - power-on or soft reset loads 0x0014
// - restart keeps bit 4, forces period 100
// - mode write of 11 triggers soft reset
module hwdc_ctrl_regs #(
	parameter int RST_LONG_CYC  = hwdc_pkg::RST_DLY_LONG_CYC,
	parameter int RST_SHORT_CYC = hwdc_pkg::RST_DLY_SHRT_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [6:0]  regAddr,
	input  wire logic        regWrEn,
	input  wire logic [15:0] regWrData,
	input  wire logic        regRdEn,
	output logic      [15:0] regRdData,
	output logic             regRdValid,
	input  wire logic        restartEvent,
	input  wire logic [1:0]  devMode,
	input  wire logic        thermEvent,
	input  wire logic        thermRunClear,
	output logic             thermalReleaseDelaySel,
	output logic             thermalLongWait,
	output logic             supplyOvThresholdSel,
	output logic             gateSampleHoldOff,
	output logic             resetOutputDelaySel,
	output logic             softResetPinOption,
	output logic             stopWdgOffBitHi,
	output logic             stopWdgOffBitLo,
	output logic             stopWdgOff,
	output logic             wdgTypeSel,
	output logic             wdgStartOnBusWake,
	output logic      [2:0]  wdgPeriodCode,
	output logic      [13:0] wdgPeriodMs,
	output logic             wdgChecksumBit,
	output logic             softResetPulse,
	output logic             resetOutputN
);
	// period code to milliseconds; code 110 taken as 1 s
	function automatic logic [13:0] periodMs(input logic [2:0] code);
		logic [13:0] ms;
		ms = hwdc_pkg::WDG_MS_C0;
		case (code)
			3'h0:    ms = hwdc_pkg::WDG_MS_C0;
			3'h1:    ms = hwdc_pkg::WDG_MS_C1;
			3'h2:    ms = hwdc_pkg::WDG_MS_C2;
			3'h3:    ms = hwdc_pkg::WDG_MS_C3;
			3'h4:    ms = hwdc_pkg::WDG_MS_C4;
			3'h5:    ms = hwdc_pkg::WDG_MS_C5;
			3'h6:    ms = hwdc_pkg::WDG_MS_C6;
			3'h7:    ms = hwdc_pkg::WDG_MS_C7;
			default: ms = hwdc_pkg::WDG_MS_C0;
		endcase
		return ms;
	endfunction

	logic [15:0] hardCtl_ff;
	logic [15:0] wdgCtl_ff;
	logic [15:0] rdData_ff;
	logic        rdValid_ff;
	logic [1:0]  prevMode_ff;
	logic [4:0]  thermRun_ff;
	logic        longWait_ff;
	logic [13:0] periodMs_ff;
	logic        softPulse_ff;
	logic        stopOff_ff;
	logic        pinN;

	logic        wrHard;
	logic        wrWdg;
	logic        softHit;
	logic        stopToNormal;
	logic        pinStart;
	logic [2:0]  periodCode;

	// address decode of the write strobe
	assign wrHard = regWrEn && (regAddr == hwdc_pkg::ADDR_HARD_CTL);
	assign wrWdg  = regWrEn && (regAddr == hwdc_pkg::ADDR_WDG_CTL);

	// soft reset is a mode write of 11 to the neighbouring register
	assign softHit = regWrEn && (regAddr == hwdc_pkg::ADDR_MODE_SUPPLY) &&
		(regWrData[hwdc_pkg::MODE_HI:hwdc_pkg::MODE_LO] == hwdc_pkg::MODE_SOFT_RESET);

	// leaving stop mode for normal mode, seen on the mode input
	assign stopToNormal = (prevMode_ff == hwdc_pkg::MODE_STOP) &&
		(devMode == hwdc_pkg::MODE_NORMAL);

	// reset pin pulses only when the option bit asks for it
	assign pinStart = softHit && !hardCtl_ff[hwdc_pkg::HC_SOFT_PIN];

	assign periodCode = wdgCtl_ff[hwdc_pkg::WC_PER_HI:hwdc_pkg::WC_PER_LO];

	// mode history for the stop-to-normal edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prevMode_ff <= hwdc_pkg::MODE_NORMAL;
		end else begin
			prevMode_ff <= devMode;
		end
	end

	// hardware control register; resets outrank writes, writes outrank auto-clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hardCtl_ff <= hwdc_pkg::HC_POR_VAL;
		end else if (softHit) begin
			hardCtl_ff <= hardCtl_ff & hwdc_pkg::HC_SOFT_KEEP;
		end else if (restartEvent) begin
			hardCtl_ff <= hardCtl_ff & hwdc_pkg::HC_RESTART_KEEP;
		end else if (wrHard) begin
			// fields take data, reserved positions stay zero
			hardCtl_ff <= regWrData & hwdc_pkg::HC_WR_MASK;
		end else if (stopToNormal) begin
			hardCtl_ff[hwdc_pkg::HC_STOP_WDG_HI] <= 1'b0;
		end
	end

	// watchdog control register; checksum bit stored as written
	always_ff @(posedge clk_sys) begin
		if (rst || softHit) begin
			wdgCtl_ff <= hwdc_pkg::WC_POR_VAL;
		end else if (restartEvent) begin
			wdgCtl_ff <= (wdgCtl_ff & hwdc_pkg::WC_RESTART_KEEP) |
				hwdc_pkg::WC_RESTART_SET;
		end else if (wrWdg) begin
			wdgCtl_ff <= regWrData & hwdc_pkg::WC_WR_MASK;
		end
	end

	// read port; unmapped and foreign addresses answer zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdData_ff  <= 16'h0000;
			rdValid_ff <= 1'b0;
		end else begin
			rdValid_ff <= regRdEn;
			if (!regRdEn) begin
				rdData_ff <= 16'h0000;
			end else if (regAddr == hwdc_pkg::ADDR_HARD_CTL) begin
				rdData_ff <= hardCtl_ff & hwdc_pkg::HC_WR_MASK;
			end else if (regAddr == hwdc_pkg::ADDR_WDG_CTL) begin
				rdData_ff <= wdgCtl_ff & hwdc_pkg::WC_WR_MASK;
			end else begin
				rdData_ff <= 16'h0000;
			end
		end
	end

	// consecutive thermal shutdown run; a new event beats a clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			thermRun_ff <= 5'h00;
		end else if (thermEvent) begin
			if (thermRun_ff != hwdc_pkg::THERM_RUN_SAT) begin
				thermRun_ff <= thermRun_ff + 5'h01;
			end
		end else if (thermRunClear) begin
			thermRun_ff <= 5'h00;
		end
	end

	// extended wait only when selected and run exceeds the limit
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			longWait_ff <= 1'b0;
		end else begin
			longWait_ff <= hardCtl_ff[hwdc_pkg::HC_THERM_DLY] &&
				(thermRun_ff > hwdc_pkg::THERM_RUN_LIMIT);
		end
	end

	// decoded watchdog period for the watchdog engine
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			periodMs_ff <= 14'h0000;
		end else begin
			periodMs_ff <= periodMs(periodCode);
		end
	end

	// watchdog off in stop mode needs both bits, a guard against one stray write
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stopOff_ff <= 1'b0;
		end else begin
			stopOff_ff <= hardCtl_ff[hwdc_pkg::HC_STOP_WDG_HI] &&
				wdgCtl_ff[hwdc_pkg::WC_STOP_WDG_LO];
		end
	end

	// one-cycle notice of a soft reset for the rest of the chip
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			softPulse_ff <= 1'b0;
		end else begin
			softPulse_ff <= softHit;
		end
	end

	// reset pin timing; bit 9 survives soft reset so the choice stays valid
	hwdc_rst_pulse #(
		.LONG_CYC  (RST_LONG_CYC),
		.SHORT_CYC (RST_SHORT_CYC)
	) u_rst_pulse (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.start    (pinStart),
		.shortSel (hardCtl_ff[hwdc_pkg::HC_RST_DLY]),
		.pinN     (pinN)
	);

	// register fields drive the control outputs directly
	assign thermalReleaseDelaySel = hardCtl_ff[hwdc_pkg::HC_THERM_DLY];
	assign supplyOvThresholdSel   = hardCtl_ff[hwdc_pkg::HC_SUPPLY_OV];
	assign gateSampleHoldOff      = hardCtl_ff[hwdc_pkg::HC_SH_OFF];
	assign resetOutputDelaySel    = hardCtl_ff[hwdc_pkg::HC_RST_DLY];
	assign softResetPinOption     = hardCtl_ff[hwdc_pkg::HC_SOFT_PIN];
	assign stopWdgOffBitHi        = hardCtl_ff[hwdc_pkg::HC_STOP_WDG_HI];
	assign stopWdgOffBitLo        = wdgCtl_ff[hwdc_pkg::WC_STOP_WDG_LO];
	assign wdgTypeSel             = wdgCtl_ff[hwdc_pkg::WC_TYPE];
	assign wdgStartOnBusWake      = wdgCtl_ff[hwdc_pkg::WC_BUS_WAKE];
	assign wdgChecksumBit         = wdgCtl_ff[hwdc_pkg::WC_CHECKSUM];
	assign wdgPeriodCode          = periodCode;

	// status and pulse outputs
	assign stopWdgOff      = stopOff_ff;
	assign thermalLongWait = longWait_ff;
	assign wdgPeriodMs     = periodMs_ff;
	assign regRdData       = rdData_ff;
	assign regRdValid      = rdValid_ff;
	assign softResetPulse  = softPulse_ff;
	assign resetOutputN    = pinN;

	// checks next to the logic they guard
	a_hard_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
		(hardCtl_ff & ~hwdc_pkg::HC_WR_MASK) == 16'h0000)
		else $error("reserved hardware control bit set");

	a_wdg_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
		(wdgCtl_ff & ~hwdc_pkg::WC_WR_MASK) == 16'h0000)
		else $error("reserved watchdog control bit set");

	a_por_values: assert property (@(posedge clk_sys)
		$past(rst) |-> (hardCtl_ff == hwdc_pkg::HC_POR_VAL) &&
		(wdgCtl_ff == hwdc_pkg::WC_POR_VAL))
		else $error("wrong value after power-on reset");

	a_soft_keeps_dly: assert property (@(posedge clk_sys) disable iff (rst)
		softHit |=> hardCtl_ff == ($past(hardCtl_ff) & hwdc_pkg::HC_SOFT_KEEP))
		else $error("soft reset did not keep only the delay bit");

	a_soft_wdg_load: assert property (@(posedge clk_sys) disable iff (rst)
		softHit |=> wdgCtl_ff == hwdc_pkg::WC_POR_VAL)
		else $error("soft reset watchdog value wrong");

	a_restart_hard: assert property (@(posedge clk_sys) disable iff (rst)
		restartEvent && !softHit |=>
		hardCtl_ff == ($past(hardCtl_ff) & hwdc_pkg::HC_RESTART_KEEP))
		else $error("restart hardware control value wrong");

	a_restart_wdg: assert property (@(posedge clk_sys) disable iff (rst)
		restartEvent && !softHit |=> (wdgCtl_ff == (($past(wdgCtl_ff) &
		hwdc_pkg::WC_RESTART_KEEP) | hwdc_pkg::WC_RESTART_SET)))
		else $error("restart watchdog value wrong");

	a_stop_exit_clear: assert property (@(posedge clk_sys) disable iff (rst)
		stopToNormal && !wrHard && !softHit && !restartEvent |=> !stopWdgOffBitHi)
		else $error("stop bit not cleared on exit to normal");

	a_hard_write_take: assert property (@(posedge clk_sys) disable iff (rst)
		wrHard && !softHit && !restartEvent |=>
		hardCtl_ff == ($past(regWrData) & hwdc_pkg::HC_WR_MASK))
		else $error("hardware control write not taken");

	a_wdg_write_take: assert property (@(posedge clk_sys) disable iff (rst)
		wrWdg && !softHit && !restartEvent |=>
		wdgCtl_ff == ($past(regWrData) & hwdc_pkg::WC_WR_MASK))
		else $error("watchdog control write not taken");

	a_soft_pin_low: assert property (@(posedge clk_sys) disable iff (rst)
		pinStart |=> !resetOutputN [*2])
		else $error("reset pin not pulled low on soft reset");

	a_soft_pin_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		softHit && softResetPinOption && resetOutputN |=> resetOutputN)
		else $error("reset pin pulsed despite option");

	a_period_decode: assert property (@(posedge clk_sys) disable iff (rst)
		!$past(rst) |-> wdgPeriodMs == periodMs($past(periodCode)))
		else $error("watchdog period decode wrong");

	a_long_wait: assert property (@(posedge clk_sys) disable iff (rst)
		!$past(rst) |-> thermalLongWait == ($past(thermalReleaseDelaySel) &&
		($past(thermRun_ff) > hwdc_pkg::THERM_RUN_LIMIT)))
		else $error("thermal long wait flag wrong");

	a_soft_notice: assert property (@(posedge clk_sys) disable iff (rst)
		softHit |=> softResetPulse ##1 (softResetPulse == $past(softHit)))
		else $error("soft reset notice missing");

	a_stop_off_both: assert property (@(posedge clk_sys) disable iff (rst)
		!$past(rst) |-> stopWdgOff == ($past(stopWdgOffBitHi) && $past(stopWdgOffBitLo)))
		else $error("stop-mode watchdog off flag wrong");

	// read port answers one cycle later, zero where nothing is mapped
	a_read_valid_next: assert property (@(posedge clk_sys) disable iff (rst)
		!$past(rst) |-> regRdValid == $past(regRdEn))
		else $error("read valid not one cycle after strobe");

	a_unmapped_read_zero: assert property (@(posedge clk_sys) disable iff (rst)
		regRdEn && (regAddr != hwdc_pkg::ADDR_HARD_CTL) &&
		(regAddr != hwdc_pkg::ADDR_WDG_CTL) |=> regRdData == 16'h0000)
		else $error("unmapped read not zero");

	// a mode write other than soft reset must leave both registers alone
	a_mode_write_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		regWrEn && (regAddr == hwdc_pkg::ADDR_MODE_SUPPLY) && !softHit &&
		!restartEvent && !stopToNormal |=> $stable(hardCtl_ff) && $stable(wdgCtl_ff))
		else $error("mode write disturbed the control registers");

	// an event must count even when a clear arrives with it
	a_therm_event_wins: assert property (@(posedge clk_sys) disable iff (rst)
		thermEvent |=> thermRun_ff == (($past(thermRun_ff) == hwdc_pkg::THERM_RUN_SAT) ?
		hwdc_pkg::THERM_RUN_SAT : $past(thermRun_ff) + 5'h01))
		else $error("thermal run not advanced by an event");
endmodule
`default_nettype wire

// [testbench/hwdc_host_model.sv]
// Purpose: host controller model driving the control register port
// Assumes: tasks are entered at any time; each waits for a rising edge first
// Notes:   data lines are inverted once released, so a stale value never looks valid
`timescale 1ns/1ps
`default_nettype none
module hwdc_host_model (
	input  wire logic        clk_sys,
	output logic      [6:0]  regAddr,
	output logic             regWrEn,
	output logic      [15:0] regWrData,
	output logic             regRdEn,
	input  wire logic [15:0] regRdData,
	input  wire logic        regRdValid
);
	// quiet bus from time zero
	initial begin
		regAddr   = 7'h00;
		regWrEn   = 1'b0;
		regWrData = 16'h0000;
		regRdEn   = 1'b0;
	end

	// one write; the word carries bit 15 exactly as the caller built it
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		#1;
		regAddr   = a;
		regWrData = d;
		regWrEn   = 1'b1;
		@(posedge clk_sys);
		#1;
		regWrEn   = 1'b0;
		regWrData = ~d;
	endtask

	// one read; the answer is taken one cycle after the strobe edge
	task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic v);
		@(posedge clk_sys);
		#1;
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge clk_sys);
		#1;
		regRdEn = 1'b0;
		v       = regRdValid;
		d       = regRdData;
	endtask

	// mode field 11 asks the device for a soft reset
	task automatic softRst();
		wr(7'h01, 16'hc000);
	endtask
endmodule
`default_nettype wire

// [testbench/hw_and_watchdog_ctrl_regs_tb.sv]
// Purpose: self-checking bench for the hardware and watchdog control registers
// Assumes: reset delays shortened to 20 and 8 cycles
// Notes:   random words from a fixed-seed xorshift plus hand-picked corner words
`timescale 1ns/1ps
`default_nettype none
module hw_and_watchdog_ctrl_regs_tb;
	localparam int LONG  = 20;
	localparam int SHORT = 8;
	localparam logic [13:0] PER [8] = '{14'h000a, 14'h0014, 14'h0032, 14'h0064,
		14'h00c8, 14'h01f4, 14'h03e8, 14'h2710};
	logic        clk_sys, rst, regWrEn, regRdEn, regRdValid, restartEvent;
	logic        thermEvent, thermRunClear, tDly, tLong, ovSel, shOff, rDly, sPin;
	logic        offHi, offLo, stopOff, wType, busWake, chkBit, srPulse, resetOutputN;
	logic [1:0]  devMode;
	logic [2:0]  perCode;
	logic [6:0]  regAddr;
	logic [13:0] perMs;
	logic [15:0] regWrData, regRdData, rdD, h, w;
	logic [31:0] seed = 32'h00015380;
	logic        rdV;
	int          numErrors, numChecks, cyc, n;
	wire  [15:0] hwOut = {3'h0, tDly, ovSel, shOff, rDly, 2'h0, sPin, 3'h0, offHi, 2'h0};
	wire  [15:0] wdOut = {chkBit, 8'h00, offLo, wType, busWake, 1'b0, perCode};

	hwdc_ctrl_regs #(.RST_LONG_CYC(LONG), .RST_SHORT_CYC(SHORT)) uut (
		.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .restartEvent(restartEvent), .devMode(devMode),
		.thermEvent(thermEvent), .thermRunClear(thermRunClear),
		.thermalReleaseDelaySel(tDly), .thermalLongWait(tLong),
		.supplyOvThresholdSel(ovSel), .gateSampleHoldOff(shOff),
		.resetOutputDelaySel(rDly), .softResetPinOption(sPin), .stopWdgOffBitHi(offHi),
		.stopWdgOffBitLo(offLo), .stopWdgOff(stopOff), .wdgTypeSel(wType),
		.wdgStartOnBusWake(busWake), .wdgPeriodCode(perCode), .wdgPeriodMs(perMs),
		.wdgChecksumBit(chkBit), .softResetPulse(srPulse), .resetOutputN(resetOutputN));

	hwdc_host_model host (
		.clk_sys(clk_sys), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
		.regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid));

	// free-running 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 6000) begin
			numErrors++;
			test_done();
		end
	end

	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		numChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rdChk(input logic [6:0] a, input logic [15:0] exp);
		host.rd(a, rdD, rdV);
		chk({15'h0000, rdV}, 16'h0001);
		chk(rdD, exp);
	endtask

	task automatic cycles(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask

	// counts how long the reset pin stays low from now
	task automatic lowCount();
		n = 0;
		while (resetOutputN === 1'b0 && n < 60) begin
			n++;
			cycles(1);
		end
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		restartEvent = 1'b0;
		devMode = 2'h0;
		thermEvent = 1'b0;
		thermRunClear = 1'b0;
		cycles(12);
		rst = 1'b0;
		lowCount();
		chk({15'h0000, (n >= LONG) && (n <= LONG + 2)}, 16'h0001);
		rdChk(7'h02, 16'h0000);
		rdChk(7'h03, 16'h0014);
		chk({2'h0, perMs}, {2'h0, PER[4]});
		rdChk(7'h01, 16'h0000);
		$display("test reset done");
		// period code from the pass number, other bits random; first pass all ones
		for (int i = 0; i < 16; i++) begin
			h = (i == 0) ? 16'hffff : rnd();
			w = (i == 0) ? 16'hffff : ((rnd() & 16'hfff8) | {13'h0000, 3'(i)});
			host.wr(7'h02, h);
			chk(hwOut, h & 16'h1e44);
			rdChk(7'h02, h & 16'h1e44);
			host.wr(7'h03, w);
			chk(wdOut, w & 16'h8077);
			rdChk(7'h03, w & 16'h8077);
			chk({2'h0, perMs}, {2'h0, PER[w[2:0]]});
			chk({15'h0000, stopOff}, {15'h0000, h[2] & w[6]});
			// a mode write that is not a soft reset must change nothing here
			host.wr(7'h01, h & 16'hbfff);
			chk({15'h0000, srPulse}, 16'h0000);
			rdChk(7'h03, w & 16'h8077);
			host.wr(7'h05, 16'hffff);
			rdChk(7'h05, 16'h0000);
			rdChk(7'h02, h & 16'h1e44);
		end
		$display("test fields done");
		// restart keeps only its documented bits
		for (int i = 0; i < 3; i++) begin
			h = (i == 0) ? 16'hffff : rnd();
			w = (i == 0) ? 16'hffff : rnd();
			host.wr(7'h02, h);
			host.wr(7'h03, w);
			restartEvent = 1'b1;
			cycles(1);
			restartEvent = 1'b0;
			rdChk(7'h02, h & 16'h1240);
			rdChk(7'h03, (w & 16'h0010) | 16'h0004);
		end
		$display("test restart done");
		// soft reset: short pin pulse, long pin pulse, no pulse
		for (int i = 0; i < 3; i++) begin
			h = (i == 0) ? 16'h0200 : (i == 1) ? 16'h0000 : 16'h1e44;
			host.wr(7'h02, h);
			host.wr(7'h03, 16'hffff);
			host.softRst();
			chk({15'h0000, srPulse}, 16'h0001);
			lowCount();
			chk(16'(n), 16'(h[6] ? 0 : (h[9] ? SHORT : LONG) + 1));
			rdChk(7'h02, h & 16'h0200);
			rdChk(7'h03, 16'h0014);
		end
		$display("test soft reset done");
		// leaving stop clears only the hardware-side stop bit
		host.wr(7'h02, 16'h0004);
		host.wr(7'h03, 16'h0040);
		devMode = 2'h2;
		cycles(2);
		chk({15'h0000, offHi}, 16'h0001);
		devMode = 2'h0;
		cycles(2);
		chk({15'h0000, offHi}, 16'h0000);
		chk({15'h0000, offLo}, 16'h0001);
		$display("test stop exit done");
		// sixteen events stay short, the seventeenth extends the wait
		host.wr(7'h02, 16'h1000);
		thermEvent = 1'b1;
		cycles(16);
		thermEvent = 1'b0;
		cycles(2);
		chk({15'h0000, tLong}, 16'h0000);
		thermEvent = 1'b1;
		cycles(1);
		thermEvent = 1'b0;
		cycles(2);
		chk({15'h0000, tLong}, 16'h0001);
		// an event beats a clear in the same cycle, so the run survives
		thermEvent = 1'b1;
		thermRunClear = 1'b1;
		cycles(1);
		thermEvent = 1'b0;
		thermRunClear = 1'b0;
		cycles(2);
		chk({15'h0000, tLong}, 16'h0001);
		host.wr(7'h02, 16'h0000);
		cycles(2);
		chk({15'h0000, tLong}, 16'h0000);
		thermRunClear = 1'b1;
		cycles(1);
		thermRunClear = 1'b0;
		host.wr(7'h02, 16'h1000);
		cycles(2);
		chk({15'h0000, tLong}, 16'h0000);
		$display("test thermal done");
		test_done();
	end
endmodule
`default_nettype wire
